// >>> sub_idx_core.v
// Decoder and executor for five single-cycle subtract and indexed instructions
// Function
// - Literal minus accumulator into accumulator, updating N, OV, C, DC, Z.
// - Literal minus accumulator is one word, one four-phase instruction cycle.
// - File minus accumulator into accumulator (d=0) or file (d=1), flags updated.
// - Access bit 0 selects access bank; 1 uses bank selector for bank.
// - a=0, extended set, address <= 95: use index pointer two plus offset.
// - File minus accumulator is one word and one four-phase cycle.
// - Indexed add: accumulator plus byte at pointer+offset, to acc or byte.
// - Indexed bit set: set bit b at pointer+offset, flags unchanged.
// - Indexed fill: write FFh to pointer+offset, flags unchanged, one cycle.
`timescale 1ns/1ps
`include "sub_idx_defs.vh"

module sub_idx_core (
    input wire clk,
    input wire reset_n,
    input wire instr_valid,
    input wire [15:0] instr_word,
    input wire ext_set_en,
    input wire [3:0] bank_selector,
    input wire [11:0] index_pointer_two,
    input wire [7:0] mem_rdata,
    output reg [11:0] mem_addr,
    output reg mem_rd,
    output reg mem_wr,
    output reg [7:0] mem_wdata,
    output reg [7:0] acc,
    output reg [4:0] status,
    output reg busy,
    output reg done,
    output reg illegal
);

// ----------------------------------------
// Decode
// ----------------------------------------
wire [7:0] hi = instr_word[15:8];
wire [7:0] lo = instr_word[7:0];
wire is_lit = (hi == `OPC_LIT_MINUS_ACC);
wire is_fsub = (hi[7:2] == `OPC_FILE_MINUS_ACC_HI);
wire is_add = (hi[7:2] == `OPC_IDX_ADD_HI) && !hi[0] && ext_set_en;
wire is_bset = (hi[7:4] == `OPC_IDX_BIT_SET_HI) && !hi[0] && ext_set_en;
wire is_fill = (hi == `OPC_IDX_FILL) && ext_set_en;
wire known = is_lit | is_fsub | is_add | is_bset | is_fill;

// Latched instruction fields
reg [1:0] phase_reg;
reg [2:0] op_reg;
reg [7:0] k_reg;
reg d_reg;
reg [2:0] bit_reg;
reg [7:0] operand_reg;
localparam OP_LIT = 3'h0;
localparam OP_FSUB = 3'h1;
localparam OP_ADD = 3'h2;
localparam OP_BSET = 3'h3;
localparam OP_FILL = 3'h4;

// ----------------------------------------
// Operation select
// ----------------------------------------
// Decode terms folded into the latched operation code. Fill is the fallback
// because the known term already screens out every other word.
reg [2:0] op_next;
always @* begin
    op_next = OP_FILL;
    if (is_lit) begin
        op_next = OP_LIT;
    end else if (is_fsub) begin
        op_next = OP_FSUB;
    end else if (is_add) begin
        op_next = OP_ADD;
    end else if (is_bset) begin
        op_next = OP_BSET;
    end
end

// Only operations with a memory operand issue a read in the read phase;
// literal and fill never touch the read port
wire needs_read = !is_lit && !is_fill;

// ----------------------------------------
// Address formation
// ----------------------------------------
// The address is formed from the live word in the decode phase and then
// registered, so mem_addr stands for the whole instruction and the write
// phase reuses it without recomputing from inputs that may have moved.
reg [11:0] addr_next;
always @* begin
    addr_next = index_pointer_two + {5'h00, instr_word[6:0]};
    if (is_fsub) begin
        if (instr_word[8]) begin
            addr_next = {bank_selector, lo};
        end else if (ext_set_en && (lo <= `IDX_OFFSET_MAX)) begin
            addr_next = index_pointer_two + {4'h0, lo};
        end else begin
            // Access bank: offsets up to 5Fh map to bank 0, offsets 60h and above to bank F
            addr_next = (lo <= `IDX_OFFSET_MAX) ? {4'h0, lo} : {4'hF, lo};
        end
    end
end

// ----------------------------------------
// Arithmetic
// ----------------------------------------
// One adder serves add and both subtract forms. The minuend or first
// addend is the literal or the fetched operand; the accumulator is always
// the second operand, inverted for subtraction.
reg [7:0] a_op;
reg [7:0] b_op;
reg sub_mode;
always @* begin
    a_op = (op_reg == OP_LIT) ? k_reg : operand_reg;
    b_op = acc;
    sub_mode = (op_reg == OP_LIT) || (op_reg == OP_FSUB);
end
// Subtract is a + ~b + 1, so carry out equals not-borrow
wire [8:0] sum9 = {1'b0, a_op} + {1'b0, (sub_mode ? ~b_op : b_op)} + {8'h00, sub_mode};
wire [4:0] sum5 = {1'b0, a_op[3:0]} + {1'b0, (sub_mode ? ~b_op[3:0] : b_op[3:0])}
    + {4'h0, sub_mode};
wire [7:0] res = sum9[7:0];
wire bx7 = sub_mode ? ~b_op[7] : b_op[7];
wire ov = (a_op[7] == bx7) && (res[7] != a_op[7]);
// Flag terms, packed as {N, OV, Z, DC, C}
wire flag_n = res[7];
wire flag_ov = ov;
wire flag_z = (res == 8'h00);
wire flag_dc = sum5[4];
// Carry out of a + ~b + 1 is the inverted borrow
wire flag_c = sum9[8];
wire [4:0] flags_new = {flag_n, flag_ov, flag_z, flag_dc, flag_c};
wire [7:0] bset_val = operand_reg | (8'h01 << bit_reg);

// ----------------------------------------
// Four-phase sequencer
// ----------------------------------------
// Decode latches the word and requests the operand, read captures it,
// process lets the adder settle, write commits the destination. Strobes
// are cleared every cycle so each one stands for exactly one clock.
// A new word is only looked at in the decode phase, so words offered
// while busy are ignored rather than queued.
always @(posedge clk) begin
    if (!reset_n) begin
        phase_reg <= `PH_DECODE;
        op_reg <= OP_LIT;
        k_reg <= 8'h00;
        d_reg <= 1'b0;
        bit_reg <= 3'h0;
        operand_reg <= 8'h00;
        mem_addr <= 12'h000;
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
        mem_wdata <= 8'h00;
        acc <= 8'h00;
        status <= 5'h00;
        busy <= 1'b0;
        done <= 1'b0;
        illegal <= 1'b0;
    end else begin
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
        done <= 1'b0;
        illegal <= 1'b0;
        case (phase_reg)
            `PH_DECODE: begin
                if (instr_valid) begin
                    if (known) begin
                        k_reg <= lo;
                        d_reg <= instr_word[9];
                        bit_reg <= instr_word[11:9];
                        mem_addr <= addr_next;
                        mem_rd <= needs_read; // Read phase request
                        busy <= 1'b1;
                        phase_reg <= `PH_READ;
                        op_reg <= op_next;
                    end else begin
                        illegal <= 1'b1;
                    end
                end
            end
            `PH_READ: begin
                // Data returns in the same cycle as the read strobe
                operand_reg <= mem_rdata;
                phase_reg <= `PH_PROCESS;
            end
            `PH_PROCESS: begin
                // Adder inputs are all registered here, so the result
                // is settled well before the write phase commits it
                phase_reg <= `PH_WRITE;
            end
            `PH_WRITE: begin
                case (op_reg)
                    OP_LIT: begin
                        acc <= res;
                        status <= flags_new;
                    end
                    OP_FSUB, OP_ADD: begin
                        status <= flags_new;
                        if (d_reg) begin
                            mem_wr <= 1'b1;
                            mem_wdata <= res;
                        end else begin
                            acc <= res;
                        end
                    end
                    OP_BSET: begin
                        mem_wr <= 1'b1;
                        mem_wdata <= bset_val;
                    end
                    default: begin
                        mem_wr <= 1'b1;
                        mem_wdata <= `FILL_VALUE;
                    end
                endcase
                busy <= 1'b0;
                done <= 1'b1;
                phase_reg <= `PH_DECODE;
            end
            default: phase_reg <= `PH_DECODE;
        endcase
    end
end

endmodule // sub_idx_core

// >>> sub_idx_defs.vh
// Constants for the subtract and indexed-operation decoder
`ifndef SUB_IDX_DEFS_VH
`define SUB_IDX_DEFS_VH
// Opcode patterns (upper byte of the instruction word)
`define OPC_LIT_MINUS_ACC 8'h08
`define OPC_FILE_MINUS_ACC_HI 6'h17
`define OPC_IDX_ADD_HI 6'h09
`define OPC_IDX_BIT_SET_HI 4'h8
`define OPC_IDX_FILL 8'h68
// Highest offset handled by indexed literal offset addressing
`define IDX_OFFSET_MAX 8'h5F
// Fill value
`define FILL_VALUE 8'hFF
// Status flag bit positions
`define FLAG_C 0
`define FLAG_DC 1
`define FLAG_Z 2
`define FLAG_OV 3
`define FLAG_N 4
// Phase counter codes
`define PH_DECODE 2'h0
`define PH_READ 2'h1
`define PH_PROCESS 2'h2
`define PH_WRITE 2'h3
`endif

// >>> sub_idx_sva.sv
// Port checker for the subtract and indexed decoder
`timescale 1ns/1ps
module sub_idx_sva (
    input wire clk,
    input wire reset_n,
    input wire instr_valid,
    input wire [15:0] instr_word,
    input wire ext_set_en,
    input wire [3:0] bank_selector,
    input wire [11:0] index_pointer_two,
    input wire [11:0] mem_addr,
    input wire mem_rd,
    input wire mem_wr,
    input wire [7:0] mem_wdata,
    input wire [7:0] acc,
    input wire [4:0] status,
    input wire busy,
    input wire done
);
    // Acceptance edge and low byte
    wire tk = instr_valid && !busy;
    wire [7:0] lo = instr_word[7:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Accepted words by kind
    sequence s_lit; tk && instr_word[15:8] == 8'h08; endsequence
    sequence s_file; tk && instr_word[15:10] == 6'h17; endsequence
    sequence s_bit; tk && ext_set_en && instr_word[15:12] == 4'h8 && !instr_word[8]; endsequence
    sequence s_fill; tk && ext_set_en && instr_word[15:8] == 8'h68; endsequence
    chk_lit_result: assert property (s_lit |-> ##4 done && acc == $past(lo, 4) - $past(acc, 4))
        else $error("lit result");
    chk_sub_carry: assert property (s_lit |-> ##4 status[0] == ($past(lo, 4) >= $past(acc, 4)))
        else $error("sub carry");
    chk_busy_span: assert property ($rose(busy) |-> busy[*3] ##1 (done && !busy))
        else $error("busy span");
    chk_done_pulse: assert property (done |=> !done)
        else $error("done pulse");
    chk_bank_addr: assert property (s_file ##0 instr_word[8] |-> ##1 mem_rd &&
        mem_addr == {$past(bank_selector), $past(lo)}) else $error("bank addr");
    chk_index_addr: assert property (s_file ##0 (!instr_word[8] && ext_set_en && lo <= 8'h5F)
        |-> ##1 mem_addr == $past(index_pointer_two) + $past(lo)) else $error("index addr");
    chk_bit_flags: assert property (s_bit |-> ##4 mem_wr && status == $past(status, 4))
        else $error("bit flags");
    chk_fill_write: assert property (s_fill |-> ##1 !mem_rd ##3 mem_wr && mem_wdata == 8'hFF)
        else $error("fill write");
endmodule // sub_idx_sva
bind sub_idx_core sub_idx_sva u_sub_idx_sva (.*);

// >>> testbench.sv
// Self-checking bench for the subtract and indexed decoder
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("Error %0t: mismatch", $time); end end
module testbench;
    reg clk = 0, reset_n = 0, instr_valid = 0, ext_set_en = 0;
    reg [15:0] instr_word = 0;
    reg [3:0] bank_selector = 0;
    reg [11:0] index_pointer_two = 0;
    reg [7:0] mem_rdata = 0, acc_m = 0;
    reg [4:0] st_m = 0;
    wire [11:0] mem_addr;
    wire [7:0] mem_wdata, acc;
    wire [4:0] status;
    wire mem_rd, mem_wr, busy, done, illegal;
    reg [31:0] seed = 32'h6C32;
    reg [34:0] q[$];
    reg [34:0] n;
    int fail_count = 0, num_checks = 0, i;
    sub_idx_core u_sub_idx_core (.*);
    initial forever #2.5 clk = ~clk;
    // Xorshift source
    function [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Result and flags {N,OV,Z,DC,C}; subtract adds the complement plus one
    function [12:0] alu(input [7:0] x, input [7:0] y, input s);
        reg [7:0] v;
        reg [8:0] t;
        reg [4:0] h;
        v = s ? ~y : y;
        t = x + v + s;
        h = x[3:0] + v[3:0] + s;
        return {t[7:0], t[7], x[7] == v[7] && t[7] != x[7], t[7:0] == 0, h[4], t[8]};
    endfunction
    // Offer one word and note its expected outcome
    task run(input int op);
        reg [7:0] k, d, w;
        reg [11:0] p, ad;
        reg [3:0] bk, h;
        reg [15:0] iw;
        reg [12:0] y;
        reg e, ill, wr;
        k = rnd();
        d = rnd();
        p = rnd();
        bk = rnd();
        h = rnd();
        e = rnd();
        ill = op > 1 && !e;
        wr = h[1];
        y = {acc_m, st_m};
        if (op > 1) k = k % 96;
        ad = p + k;
        case (op)
            0: begin iw = {8'h08, k}; y = alu(k, acc_m, 1); wr = 0; end
            1: begin
                iw = {6'h17, h[1:0], k};
                if (h[0]) ad = {bk, k};
                else if (!(e && k <= 8'h5F)) ad = {k > 8'h5F ? 4'hF : 4'h0, k};
                y = alu(d, acc_m, 1);
            end
            2: begin iw = {6'h09, h[1], 1'b0, k}; y = alu(acc_m, d, 0); end
            3: begin iw = {4'h8, h[2:0], 1'b0, k}; w = d | (8'h01 << h[2:0]); wr = 1; end
            4: begin iw = {8'h68, k}; w = 8'hFF; wr = 1; end
            default: begin iw = 16'hFFFF; ill = 1; end
        endcase
        if (wr && op < 3) begin w = y[12:5]; y[12:5] = acc_m; end
        if (ill) begin y = {acc_m, st_m}; wr = 0; end
        {acc_m, st_m} = y;
        q.push_back({ill, wr, y, w, ad});
        @(posedge clk);
        instr_word <= iw;
        instr_valid <= 1;
        ext_set_en <= e;
        bank_selector <= bk;
        index_pointer_two <= p;
        mem_rdata <= d;
        @(posedge clk);
        instr_valid <= 0;
        repeat (5) @(posedge clk);
    endtask
    // Compare each completion with the oldest note
    always @(negedge clk) if (done === 1'b1 || illegal === 1'b1) begin
        n = q.pop_front();
        `CHK(illegal, n[34])
        `CHK(mem_wr, n[33])
        `CHK(busy, 1'b0)
        `CHK({acc, status}, n[32:20])
        if (n[33]) `CHK({mem_wr, mem_wdata, mem_addr}, {1'b1, n[19:0]})
    end
    task tally_and_finish();
        if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1;
        for (i = 0; i < 90; i++) run(rnd() % 6);
        `CHK(q.size(), 0)
        tally_and_finish();
    end
    initial begin
        #6000;
        fail_count++;
        tally_and_finish();
    end
endmodule // testbench
